// >>> core/dpc_dac_core.sv
// mono dac processing core, double-buffered coefficients
`timescale 1ns/1ps
`default_nettype none
module dpc_dac_core (
  // clock, reset and freeze
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // host register port
  input wire logic [7:0] reg_page,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // audio sample input
  input wire logic sample_valid,
  input wire logic [dpc_pkg::COEF_W-1:0] left_sample,
  input wire logic [dpc_pkg::COEF_W-1:0] right_sample,
  // modulator output
  output logic mod_valid,
  output logic [dpc_pkg::COEF_W-1:0] mod_data,
  output logic dac_running
);
  import dpc_pkg::*;

  // bank page register to {hit, index}
  function automatic logic [7:0] coef_slot(input logic [1:0] sub, input logic [6:0] ra);
    logic [6:0] start;
    logic [6:0] base;
    logic [6:0] idx;
    start = (sub == 2'h0) ? COEF_START_FIRST : COEF_START_OTHER;
    base = (sub == 2'h0) ? 7'h00 : (sub == 2'h1) ? COEF_BASE_PAGE1 : COEF_BASE_PAGE2;
    idx = 7'(base + ((ra - start) >> 2));
    coef_slot = {(sub != 2'h3) && (ra >= start) && (ra <= COEF_LAST_REG) &&
                 (ra[1:0] != 2'h3) && (idx < 7'(NUM_COEFS)), idx};
  endfunction : coef_slot

  // saturate to 24 bits, msb flags a clip
  function automatic logic [COEF_W:0] sat24(input logic signed [ACC_W-1:0] v);
    if (v > 56'sh7fffff) begin
      sat24 = {1'b1, 24'h7fffff};
    end else if (v < -56'sh800000) begin
      sat24 = {1'b1, 24'h800000};
    end else begin
      sat24 = {1'b0, v[COEF_W-1:0]};
    end
  endfunction : sat24

  // host registers
  logic [7:0] osr_upper; // ratio bits 9:8
  logic [7:0] osr_lower; // ratio bits 7:0
  logic [7:0] setup; // power and source select
  logic [7:0] block_sel; // processing block choice
  logic [7:0] mute_ctrl; // mute and auto mute enables
  logic [7:0] volume; // signed half-dB steps
  logic [7:0] adapt_ctrl; // adaptive mode enable
  logic clip_flag; // sticky, read clears
  logic switch_req; // pending bank swap
  logic bank_sel; // bank in use by the engine
  // engine state
  dpc_state_t state;
  logic [2:0] sec; // 0 iir, 1..6 biquads
  logic [2:0] tap; // coefficient within a section
  logic signed [ACC_W-1:0] acc;
  logic signed [COEF_W-1:0] x_cur; // section in/out
  logic signed [COEF_W-1:0] x1 [NUM_SECTIONS];
  logic signed [COEF_W-1:0] x2 [NUM_SECTIONS];
  logic signed [COEF_W-1:0] y1 [NUM_SECTIONS];
  logic signed [COEF_W-1:0] y2 [NUM_SECTIONS];
  logic signed [COEF_W-1:0] out_sample; // after volume
  logic signed [COEF_W-1:0] prev_out; // previous output
  logic [4:0] zero_cnt; // consecutive zero inputs
  logic [10:0] interp_cnt; // outputs left
  logic interp_first; // first output of a period

  dpc_coef_if cif ();

  // coefficient store
  dpc_coef_bank u_bank (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cif(cif)
  );

  // register decode
  wire running = setup[SETUP_POWER_BIT];
  wire adapt_on = adapt_ctrl[ADAPT_EN_BIT];
  wire on_ctrl = (reg_page == PAGE_CTRL);
  wire hit_switch = (reg_page == PAGE_BANK_A) && (reg_addr == REG_SWITCH);
  wire hit_adapt = (reg_page == PAGE_ADAPT) && (reg_addr == REG_ADAPT);
  wire [7:0] page_a_rel = reg_page - PAGE_BANK_A;
  wire [7:0] page_b_rel = reg_page - PAGE_BANK_B;
  wire in_a = (page_a_rel < 8'h03);
  wire in_b = (page_b_rel < 8'h03);
  wire [7:0] slot_a = coef_slot(page_a_rel[1:0], reg_addr);
  wire [7:0] slot_b = coef_slot(page_b_rel[1:0], reg_addr);
  wire coef_hit = (in_a && slot_a[7]) || (in_b && slot_b[7]);
  wire coef_locked = running && !adapt_on;
  // running: idle bank; stopped: addressed bank
  wire coef_bank = running ? !bank_sel : in_b;

  // host coefficient port
  assign cif.wr_en = ce && reg_wr && coef_hit && !coef_locked;
  assign cif.wr_bank = coef_bank;
  assign cif.wr_index = in_b ? slot_b[6:0] : slot_a[6:0];
  assign cif.wr_byte = reg_addr[1:0];
  assign cif.wr_data = reg_wdata;
  assign cif.rd_bank = coef_bank;
  assign cif.rd_index = cif.wr_index;
  assign cif.rd_byte = reg_addr[1:0];

  // read mux, unmapped or locked reads zero
  wire [7:0] rd_switch = {6'h00, bank_sel, switch_req};
  wire [7:0] next_rdata =
    (on_ctrl && reg_addr == REG_OSR_UPPER) ? osr_upper :
    (on_ctrl && reg_addr == REG_OSR_LOWER) ? osr_lower :
    (on_ctrl && reg_addr == REG_FLAG) ? {clip_flag, 7'h00} :
    (on_ctrl && reg_addr == REG_BLOCK_SEL) ? block_sel :
    (on_ctrl && reg_addr == REG_SETUP) ? setup :
    (on_ctrl && reg_addr == REG_MUTE) ? mute_ctrl :
    (on_ctrl && reg_addr == REG_VOLUME) ? volume :
    hit_adapt ? adapt_ctrl :
    hit_switch ? rd_switch :
    (coef_hit && !coef_locked) ? cif.rd_data : 8'h00;

  // read data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // host write registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osr_upper <= OSR_UPPER_RST;
      osr_lower <= OSR_LOWER_RST;
      setup <= SETUP_RST;
      block_sel <= BLOCK_SEL_RST;
      mute_ctrl <= MUTE_RST;
      volume <= VOLUME_RST;
      adapt_ctrl <= ADAPT_RST;
    end else if (ce && reg_wr) begin
      if (on_ctrl && reg_addr == REG_OSR_UPPER) osr_upper <= reg_wdata;
      if (on_ctrl && reg_addr == REG_OSR_LOWER) osr_lower <= reg_wdata;
      if (on_ctrl && reg_addr == REG_SETUP) setup <= reg_wdata;
      if (on_ctrl && reg_addr == REG_BLOCK_SEL) block_sel <= reg_wdata;
      if (on_ctrl && reg_addr == REG_MUTE) mute_ctrl <= reg_wdata;
      if (on_ctrl && reg_addr == REG_VOLUME) volume <= reg_wdata;
      if (hit_adapt) adapt_ctrl <= reg_wdata;
    end
  end

  // sample start and bank swap
  wire start = sample_valid && (state == ST_IDLE) && running;
  wire swap_now = start && switch_req && adapt_on;
  wire req_set = ce && reg_wr && hit_switch && reg_wdata[SWITCH_REQ_BIT] && running &&
                 adapt_on;

  // swap request and bank in use, set beats clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      switch_req <= 1'b0;
      bank_sel <= 1'b0;
    end else if (ce) begin
      switch_req <= req_set || (switch_req && !swap_now);
      if (swap_now) bank_sel <= !bank_sel;
    end
  end

  // mono source selection
  wire [1:0] src = setup[SETUP_SRC_LSB +: 2];
  wire signed [COEF_W:0] lr_sum = $signed({left_sample[23], left_sample}) +
                                  $signed({right_sample[23], right_sample});
  wire signed [COEF_W-1:0] mono = (src == SRC_LEFT) ? $signed(left_sample) :
                                  (src == SRC_RIGHT) ? $signed(right_sample) :
                                  (src == SRC_MIX) ? lr_sum[24:1] : 24'sh000000;

  // processing block shape
  wire use_block_two = (block_sel == BLOCK_TWO);
  wire filter_b = (block_sel == BLOCK_THREE);
  wire [2:0] first_sec = use_block_two ? 3'h1 : 3'h0;
  wire [2:0] last_sec = use_block_two ? 3'h3 : 3'h6;

  // mac operands
  wire is_iir = (sec == 3'h0);
  wire [2:0] last_tap = is_iir ? 3'h2 : 3'h4;
  wire [2:0] sec_m1 = sec - 3'h1;
  wire [6:0] bq_base = 7'({sec_m1, 2'h0} + sec_m1);
  assign cif.eng_bank = bank_sel;
  assign cif.eng_index = is_iir ? 7'(IIR_BASE + tap) : 7'(bq_base + tap);
  wire signed [COEF_W-1:0] opnd =
    (tap == 3'h0) ? x_cur :
    (tap == 3'h1) ? x1[sec] :
    (is_iir && tap == 3'h2) ? y1[sec] :
    (tap == 3'h2) ? x2[sec] :
    (tap == 3'h3) ? y1[sec] : y2[sec];
  wire dbl = !is_iir && (tap == 3'h1 || tap == 3'h3);
  wire signed [47:0] prod = $signed(cif.eng_coef) * opnd;
  wire signed [ACC_W-1:0] term = dbl ? {{7{prod[47]}}, prod, 1'b0} :
                                       {{8{prod[47]}}, prod};
  // scale by 2^-23, feedback sign in the sum
  wire [COEF_W:0] sec_sat = sat24(acc >>> 23);

  // volume: 2^(r/12) times 2^q, half-dB steps
  wire signed [7:0] vol_s = $signed(volume);
  wire signed [7:0] vol_c = (vol_s < VOL_MIN) ? VOL_MIN : (vol_s > VOL_MAX) ? VOL_MAX : vol_s;
  wire [7:0] vol_u = 8'(vol_c + VOL_OFFSET);
  wire [7:0] vol_q = vol_u / VOL_STEPS;
  wire [7:0] vol_r = vol_u % VOL_STEPS;
  wire signed [40:0] vol_prod = x_cur * $signed({1'b0, VOL_TABLE[vol_r[3:0]]});
  wire signed [ACC_W-1:0] vol_ext = ACC_W'(vol_prod) <<< vol_q[3:0];
  wire [COEF_W:0] vol_sat = sat24(vol_ext >>> VOL_SHIFT);
  wire auto_muted = mute_ctrl[AUTO_MUTE_BIT] && (zero_cnt == AUTO_MUTE_COUNT);
  wire muted = mute_ctrl[MUTE_BIT] || auto_muted;

  // engine: iir, biquads, volume
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      sec <= 3'h0;
      tap <= 3'h0;
      acc <= '0;
      x_cur <= '0;
      out_sample <= '0;
      prev_out <= '0;
      for (int s = 0; s < NUM_SECTIONS; s++) begin
        x1[s] <= '0;
        x2[s] <= '0;
        y1[s] <= '0;
        y2[s] <= '0;
      end
    end else if (ce) begin
      case (state)
        // wait for a sample
        ST_IDLE: begin
          if (start) begin
            x_cur <= mono;
            sec <= first_sec;
            tap <= 3'h0;
            acc <= '0;
            state <= ST_MAC;
          end
        end
        // one product per cycle
        ST_MAC: begin
          acc <= acc + term;
          if (tap == last_tap) begin
            state <= ST_NEXT;
          end else begin
            tap <= tap + 3'h1;
          end
        end
        // keep history, next section
        ST_NEXT: begin
          x2[sec] <= x1[sec];
          x1[sec] <= x_cur;
          y2[sec] <= y1[sec];
          y1[sec] <= sec_sat[COEF_W-1:0];
          x_cur <= sec_sat[COEF_W-1:0];
          if (sec == last_sec) begin
            state <= ST_VOL;
          end else begin
            sec <= sec + 3'h1;
            tap <= 3'h0;
            acc <= '0;
            state <= ST_MAC;
          end
        end
        // gain and mute
        ST_VOL: begin
          out_sample <= muted ? 24'sh000000 : vol_sat[COEF_W-1:0];
          prev_out <= out_sample;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // sticky clip flag, set beats read clear
  wire clip_set = (state == ST_NEXT && sec_sat[COEF_W]) ||
                  (state == ST_VOL && vol_sat[COEF_W] && !muted);
  wire clip_clr = reg_rd && on_ctrl && (reg_addr == REG_FLAG);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clip_flag <= 1'b0;
    end else if (ce) begin
      clip_flag <= clip_set || (clip_flag && !clip_clr);
    end
  end

  // zero input run for auto mute
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      zero_cnt <= 5'h00;
    end else if (ce && start) begin
      if (mono != 24'sh000000) begin
        zero_cnt <= 5'h00;
      end else if (zero_cnt != AUTO_MUTE_COUNT) begin
        zero_cnt <= zero_cnt + 5'h01;
      end
    end
  end

  // ratio outputs per sample, filter a averages the first
  wire [9:0] osr_field = {osr_upper[1:0], osr_lower};
  wire [10:0] osr_count = (osr_field == 10'h000) ? OSR_MAX : {1'b0, osr_field};
  wire signed [COEF_W:0] avg_sum = $signed({prev_out[23], prev_out}) +
                                   $signed({out_sample[23], out_sample});
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interp_cnt <= 11'h000;
      interp_first <= 1'b0;
      mod_valid <= 1'b0;
      mod_data <= '0;
    end else if (ce) begin
      if (!running) begin
        interp_cnt <= 11'h000;
        mod_valid <= 1'b0;
      end else if (state == ST_VOL) begin
        interp_cnt <= osr_count;
        interp_first <= 1'b1;
        mod_valid <= 1'b0;
      end else if (interp_cnt != 11'h000) begin
        mod_valid <= 1'b1;
        mod_data <= (interp_first && !filter_b) ? avg_sum[24:1] : out_sample;
        interp_cnt <= interp_cnt - 11'h001;
        interp_first <= 1'b0;
      end else begin
        mod_valid <= 1'b0;
      end
    end
  end

  assign dac_running = running;
endmodule : dpc_dac_core
`default_nettype wire

// >>> core/dpc_pkg.sv
// shared constants and types of the dac core
//
// Summary of operation
// - mono input from left, right or average
// - accept any sample rate 8 to 192 kHz
// - oversampling ratio 1..1024 from two registers
// - three processing blocks: iir, biquads, filter
// - channel setup top bit powers the dac
// - flag register top bit reports clipping
// - coefficients locked while running, adaptive off
// - adaptive bit enables coefficient double buffering
// - switch request swaps banks at sample start
// - bank indicator toggles, shows bank in use
// - running writes go to idle bank
// - coefficients on pages 44-46 and 62-64
// - 24-bit 1.23 coefficient over three registers
// - first-order iir with 2^23 normalisation
// - reset coefficients give flat iir response
// - volume -63.5..+24 dB, mute, auto mute
// - biquad with doubled middle terms
// - leading feedforward resets to 0x7fffff
package dpc_pkg;
  // widths and store size
  localparam int COEF_W = 24;
  localparam int ACC_W = 56;
  localparam int NUM_COEFS = 70;
  localparam int NUM_SECTIONS = 7;
  // register pages
  localparam logic [7:0] PAGE_CTRL = 8'h00;
  localparam logic [7:0] PAGE_ADAPT = 8'h08;
  localparam logic [7:0] PAGE_BANK_A = 8'h2c;
  localparam logic [7:0] PAGE_BANK_B = 8'h3e;
  // register offsets within a page
  localparam logic [6:0] REG_OSR_UPPER = 7'h0d;
  localparam logic [6:0] REG_OSR_LOWER = 7'h0e;
  localparam logic [6:0] REG_FLAG = 7'h27;
  localparam logic [6:0] REG_BLOCK_SEL = 7'h3c;
  localparam logic [6:0] REG_SETUP = 7'h3f;
  localparam logic [6:0] REG_MUTE = 7'h40;
  localparam logic [6:0] REG_VOLUME = 7'h41;
  localparam logic [6:0] REG_ADAPT = 7'h01;
  localparam logic [6:0] REG_SWITCH = 7'h01;
  // coefficient layout in a bank
  localparam logic [6:0] COEF_START_FIRST = 7'h0c;
  localparam logic [6:0] COEF_START_OTHER = 7'h08;
  localparam logic [6:0] COEF_LAST_REG = 7'h7e;
  localparam logic [6:0] COEF_BASE_PAGE1 = 7'h1d;
  localparam logic [6:0] COEF_BASE_PAGE2 = 7'h3b;
  localparam logic [6:0] IIR_BASE = 7'h40;
  localparam logic [6:0] BIQUAD_AREA = 7'h1e;
  // field positions
  localparam int SETUP_POWER_BIT = 7;
  localparam int SETUP_SRC_LSB = 4;
  localparam int FLAG_CLIP_BIT = 7;
  localparam int ADAPT_EN_BIT = 2;
  localparam int SWITCH_REQ_BIT = 0;
  localparam int SWITCH_BANK_BIT = 1;
  localparam int MUTE_BIT = 3;
  localparam int AUTO_MUTE_BIT = 4;
  // mono source codes
  localparam logic [1:0] SRC_LEFT = 2'h1;
  localparam logic [1:0] SRC_RIGHT = 2'h2;
  localparam logic [1:0] SRC_MIX = 2'h3;
  // processing block codes
  localparam logic [7:0] BLOCK_TWO = 8'h02;
  localparam logic [7:0] BLOCK_THREE = 8'h03;
  // reset values
  localparam logic [7:0] OSR_UPPER_RST = 8'h00;
  localparam logic [7:0] OSR_LOWER_RST = 8'h80;
  localparam logic [7:0] SETUP_RST = 8'h10;
  localparam logic [7:0] BLOCK_SEL_RST = 8'h01;
  localparam logic [7:0] MUTE_RST = 8'h00;
  localparam logic [7:0] VOLUME_RST = 8'h00;
  localparam logic [7:0] ADAPT_RST = 8'h00;
  localparam logic [COEF_W-1:0] COEF_UNITY = 24'h7fffff;
  localparam logic [COEF_W-1:0] COEF_ZERO = 24'h000000;
  // zero ratio field means the top ratio
  localparam logic [10:0] OSR_MAX = 11'h400;
  // volume half-dB steps, offset keeps index positive
  localparam logic signed [7:0] VOL_MIN = -8'sd127;
  localparam logic signed [7:0] VOL_MAX = 8'sd48;
  localparam logic [7:0] VOL_OFFSET = 8'h84;
  localparam logic [7:0] VOL_STEPS = 8'h0c;
  localparam int VOL_SHIFT = 26;
  // 2^(r/12) in 1.15 per step in an octave
  localparam logic [15:0] VOL_TABLE [12] = '{16'h8000, 16'h879c, 16'h8fad,
    16'h9838, 16'ha145, 16'haadc, 16'hb505, 16'hbfc9, 16'hcb30, 16'hd745,
    16'he412, 16'hf1a2};
  // zero inputs before auto mute
  localparam logic [4:0] AUTO_MUTE_COUNT = 5'h10;
  // engine states
  typedef enum logic [1:0] {ST_IDLE, ST_MAC, ST_NEXT, ST_VOL} dpc_state_t;
endpackage : dpc_pkg

// >>> core/dpc_coef_if.sv
// coefficient store access
`timescale 1ns/1ps
`default_nettype none
interface dpc_coef_if;
  logic wr_en; // host byte write
  logic wr_bank; // 0 bank a, 1 bank b
  logic [6:0] wr_index; // coefficient index
  logic [1:0] wr_byte; // 0 msb .. 2 lsb
  logic [7:0] wr_data;
  logic rd_bank; // host read bank
  logic [6:0] rd_index;
  logic [1:0] rd_byte;
  logic [7:0] rd_data;
  logic eng_bank; // engine bank
  logic [6:0] eng_index;
  logic [23:0] eng_coef;
  // control core side
  modport ctrl (output wr_en, wr_bank, wr_index, wr_byte, wr_data, rd_bank, rd_index,
    rd_byte, eng_bank, eng_index, input rd_data, eng_coef);
  // memory side
  modport store (input wr_en, wr_bank, wr_index, wr_byte, wr_data, rd_bank, rd_index,
    rd_byte, eng_bank, eng_index, output rd_data, eng_coef);
endinterface : dpc_coef_if
`default_nettype wire

// >>> core/dpc_coef_bank.sv
// two coefficient banks, byte and engine ports
`timescale 1ns/1ps
`default_nettype none
module dpc_coef_bank (
  // clock, reset and freeze
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // coefficient access
  dpc_coef_if.store cif
);
  import dpc_pkg::*;

  // bank 0 is a, bank 1 is b
  logic [COEF_W-1:0] mem [2][NUM_COEFS];
  logic [COEF_W-1:0] rd_word; // word under host read

  // byte write, msb at the lowest register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < NUM_COEFS; i++) begin
          // leading feedforward unity, rest zero
          if ((i < 30 && (i % 5) == 0) || i == 64) begin
            mem[b][i] <= COEF_UNITY;
          end else begin
            mem[b][i] <= COEF_ZERO;
          end
        end
      end
    end else if (ce && cif.wr_en) begin
      case (cif.wr_byte)
        2'h0: mem[cif.wr_bank][cif.wr_index][23:16] <= cif.wr_data;
        2'h1: mem[cif.wr_bank][cif.wr_index][15:8] <= cif.wr_data;
        2'h2: mem[cif.wr_bank][cif.wr_index][7:0] <= cif.wr_data;
        default: ; // fourth register unmapped
      endcase
    end
  end

  // read ports
  assign rd_word = mem[cif.rd_bank][cif.rd_index];
  assign cif.rd_data = (cif.rd_byte == 2'h0) ? rd_word[23:16] :
                       (cif.rd_byte == 2'h1) ? rd_word[15:8] :
                       (cif.rd_byte == 2'h2) ? rd_word[7:0] : 8'h00;
  assign cif.eng_coef = mem[cif.eng_bank][cif.eng_index];
endmodule : dpc_coef_bank
`default_nettype wire

// >>> verification/dpc_assertions.sv
// port checks of the dac core
`timescale 1ns/1ps
`default_nettype none
module dpc_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // host port
  input wire logic [7:0] reg_page,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // audio side
  input wire logic sample_valid,
  input wire logic mod_valid,
  input wire logic [dpc_pkg::COEF_W-1:0] mod_data,
  input wire logic dac_running
);
  import dpc_pkg::*;
  logic adapt; // adaptive bit as written
  logic [9:0] osr; // ratio field as written
  logic [10:0] run_len; // current output run
  logic [10:0] since; // cycles since a taken sample
  wire rd_go = ce && reg_rd;
  wire wr_go = ce && reg_wr;
  wire pwr_wd = reg_wdata[SETUP_POWER_BIT];
  wire ctl_pg = reg_page == PAGE_CTRL;
  wire coef_pg = reg_page inside {[8'h2c:8'h2e], [8'h3e:8'h40]};
  wire [10:0] ratio = (osr == 10'h0) ? OSR_MAX : {1'b0, osr};
  // track host writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adapt <= 1'b0;
      osr <= {2'h0, OSR_LOWER_RST};
    end else if (wr_go) begin
      if (reg_page == PAGE_ADAPT && reg_addr == REG_ADAPT) adapt <= reg_wdata[ADAPT_EN_BIT];
      if (ctl_pg && reg_addr == REG_OSR_UPPER) osr[9:8] <= reg_wdata[1:0];
      if (ctl_pg && reg_addr == REG_OSR_LOWER) osr[7:0] <= reg_wdata;
    end
  end
  // output run length and cycles since a sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= 11'h0;
      since <= 11'h7ff;
    end else if (ce) begin
      run_len <= mod_valid ? run_len + 11'h1 : 11'h0;
      if (sample_valid && dac_running) since <= 11'h0;
      else if (since != 11'h7ff) since <= since + 11'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_power_follow: assert property (wr_go && ctl_pg && reg_addr == REG_SETUP
    |=> dac_running == $past(pwr_wd)) else $error("power state not as written");
  a_power_gate: assert property (!dac_running && !$past(dac_running)
    |-> !mod_valid) else $error("output while powered down");
  a_flag_bits: assert property (rd_go && ctl_pg && reg_addr == REG_FLAG
    |=> reg_rdata[6:0] == 7'h00) else $error("flag low bits not zero");
  a_coef_locked: assert property (rd_go && coef_pg && reg_addr >= 7'h08 && dac_running
    && !adapt |=> reg_rdata == 8'h00) else $error("locked coefficient readable");
  a_rdata_hold: assert property (!$past(rd_go) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_osr_run: assert property (mod_valid && run_len < since |-> run_len < ratio)
    else $error("output run longer than ratio");
  a_mod_start: assert property ($rose(mod_valid) |-> since <= 11'd60)
    else $error("output without a recent sample");
  a_data_hold: assert property (!mod_valid |-> $stable(mod_data))
    else $error("output data moved while not valid");
  c_stream: cover property ($rose(mod_valid));
  c_locked: cover property (rd_go && coef_pg && dac_running && !adapt);
  c_switch: cover property (wr_go && adapt && dac_running && reg_page == PAGE_BANK_A);
endmodule : dpc_assertions
bind dpc_dac_core dpc_assertions chk_i (.mclk, .rst_n, .ce, .reg_page, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .sample_valid, .mod_valid, .mod_data, .dac_running);
`default_nettype wire

// >>> verification/dpc_src_model.sv
// stereo sample source
`timescale 1ns/1ps
`default_nettype none
module dpc_src_model (
  // clock and control
  input wire logic mclk,
  input wire logic run,
  input wire logic [23:0] lval,
  input wire logic [23:0] rval,
  // sample stream
  output logic sample_valid,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample
);
  logic [6:0] cnt = 7'h00; // spacing counter
  initial sample_valid = 1'b0;
  // a sample per 80 clocks, inverted between
  always @(posedge mclk) begin
    cnt <= (cnt == 7'h4f) ? 7'h00 : cnt + 7'h01;
    sample_valid <= run && cnt == 7'h00;
    left_sample <= (run && cnt == 7'h00) ? lval : ~lval;
    right_sample <= (run && cnt == 7'h00) ? rval : ~rval;
  end
endmodule : dpc_src_model
`default_nettype wire

// >>> verification/dac_processing_coef_buffers_test.sv
// self-checking dac core bench
`timescale 1ns/1ps
`default_nettype none
module dac_processing_coef_buffers_test;
  import dpc_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
  logic sample_valid, mod_valid, dac_running;
  logic [7:0] reg_page = 8'h00, reg_wdata = 8'h00, reg_rdata, q;
  logic [6:0] reg_addr = 7'h00;
  logic [23:0] lval = 24'h100000, rval = 24'h200000, left_sample, right_sample, mod_data, d;
  int n_fail = 0, check_count = 0, n;
  always #20 mclk = ~mclk;
  dpc_dac_core dut (.mclk, .rst_n, .ce(1'b1), .reg_page, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .sample_valid, .left_sample, .right_sample, .mod_valid,
    .mod_data, .dac_running);
  dpc_src_model src (.mclk, .run, .lval, .rval, .sample_valid, .left_sample,
    .right_sample);
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // tolerant compare, x fails
  task automatic chk(string nm, logic [23:0] ex, logic [23:0] got, int tol);
    logic signed [24:0] df;
    df = $signed({got[23], got}) - $signed({ex[23], ex});
    check_count++;
    if ((df <= tol && df >= -tol) !== 1'b1) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // one register access
  task automatic acc(logic w, logic [7:0] pg, logic [6:0] ad, logic [7:0] wd);
    @(posedge mclk);
    reg_page <= pg;
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : acc
  task automatic r8(string nm, logic [7:0] pg, logic [6:0] ad, logic [7:0] ex);
    acc(1'b0, pg, ad, 8'h00);
    chk(nm, {16'h0, ex}, {16'h0, q}, 0);
  endtask : r8
  // msb at lowest register
  task automatic wc(logic [7:0] pg, logic [6:0] ad, logic [23:0] c);
    for (int i = 0; i < 3; i++) acc(1'b1, pg, ad + 7'(i), c[23-8*i -: 8]);
  endtask : wc
  task automatic rc(string nm, logic [7:0] pg, logic [6:0] ad, logic [23:0] ex);
    logic [23:0] c;
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, pg, ad + 7'(i), 8'h00);
      c[23-8*i -: 8] = q;
    end
    chk(nm, ex, c, 0);
  endtask : rc
  // wait for the next sample strobe
  task automatic sync;
    int i;
    for (i = 0; i < 200 && sample_valid !== 1'b1; i++) @(posedge mclk) #1;
    if (i == 200) begin
      n_fail++;
      give_verdict;
    end
  endtask : sync
  // count outputs of one sample, keep last
  task automatic grab;
    sync;
    n = 0;
    repeat (79) begin
      @(posedge mclk) #1;
      if (mod_valid === 1'b1) begin
        n++;
        d = mod_data;
      end
    end
  endtask : grab
  task automatic sc_reset;
    r8("osr_up", PAGE_CTRL, REG_OSR_UPPER, OSR_UPPER_RST);
    r8("osr_lo", PAGE_CTRL, REG_OSR_LOWER, OSR_LOWER_RST);
    r8("setup", PAGE_CTRL, REG_SETUP, SETUP_RST);
    r8("flag", PAGE_CTRL, REG_FLAG, 8'h00);
    r8("adapt", PAGE_ADAPT, REG_ADAPT, ADAPT_RST);
    r8("switch", PAGE_BANK_A, REG_SWITCH, 8'h00);
    r8("gap", PAGE_BANK_A, 7'h0f, 8'h00);
    rc("c1_a", PAGE_BANK_A, 7'h0c, COEF_UNITY);
    rc("c2_a", PAGE_BANK_A, 7'h10, COEF_ZERO);
    rc("c65_a", 8'h2e, 7'h1c, COEF_UNITY);
    rc("c26_b", PAGE_BANK_B, 7'h70, COEF_UNITY);
    rc("c30_b", 8'h3f, 7'h08, COEF_ZERO);
  endtask : sc_reset
  task automatic sc_stopped;
    wc(PAGE_BANK_B, 7'h10, 24'h800000);
    r8("c2_b_msb", PAGE_BANK_B, 7'h10, 8'h80);
    rc("c2_b", PAGE_BANK_B, 7'h10, 24'h800000);
    rc("c2_a_kept", PAGE_BANK_A, 7'h10, COEF_ZERO);
    wc(PAGE_BANK_B, 7'h10, COEF_ZERO);
  endtask : sc_stopped
  // all blocks and sources, ratio 4, flat
  task automatic sc_stream;
    logic [23:0] ev [3] = '{24'h100000, 24'h200000, 24'h180000};
    acc(1'b1, PAGE_CTRL, REG_OSR_LOWER, 8'h04);
    run <= 1'b1;
    for (int b = 1; b < 4; b++) begin
      acc(1'b1, PAGE_CTRL, REG_BLOCK_SEL, 8'(b));
      for (int s = 0; s < 3; s++) begin
        acc(1'b1, PAGE_CTRL, REG_SETUP, {2'b10, 2'(s + 1), 4'h0});
        grab;
        grab;
        chk("ratio", 24'd4, 24'(n), 0);
        chk("mono", ev[s], d, 64);
      end
    end
    acc(1'b1, PAGE_CTRL, REG_SETUP, 8'h10);
    grab;
    chk("off", 24'd0, 24'(n), 0);
  endtask : sc_stream
  task automatic sc_adaptive;
    acc(1'b1, PAGE_CTRL, REG_SETUP, 8'h90);
    r8("locked", PAGE_BANK_A, 7'h0c, 8'h00);
    wc(PAGE_BANK_B, 7'h0c, 24'h400000);
    acc(1'b1, PAGE_BANK_A, REG_SWITCH, 8'h01);
    r8("sw_off", PAGE_BANK_A, REG_SWITCH, 8'h00);
    acc(1'b1, PAGE_ADAPT, REG_ADAPT, 8'h04);
    rc("b_dropped", PAGE_BANK_A, 7'h0c, COEF_UNITY);
    wc(PAGE_BANK_A, 7'h0c, 24'h400000);
    rc("b_new", PAGE_BANK_B, 7'h0c, 24'h400000);
    grab;
    chk("on_a", 24'h100000, d, 64);
    sync;
    acc(1'b1, PAGE_BANK_A, REG_SWITCH, 8'h01);
    r8("sw_wait", PAGE_BANK_A, REG_SWITCH, 8'h01);
    grab;
    chk("on_b", 24'h080000, d, 64);
    r8("sw_done", PAGE_BANK_A, REG_SWITCH, 8'h02);
    rc("idle_a", PAGE_BANK_B, 7'h0c, COEF_UNITY);
    acc(1'b1, PAGE_CTRL, REG_SETUP, 8'h10);
    rc("stop_b", PAGE_BANK_B, 7'h0c, 24'h400000);
  endtask : sc_adaptive
  // doubled tap at full scale clips from the second sample on
  task automatic sc_clip;
    wc(PAGE_BANK_B, 7'h10, COEF_UNITY);
    lval <= 24'h7fffff;
    acc(1'b1, PAGE_CTRL, REG_SETUP, 8'h90);
    grab;
    grab;
    run <= 1'b0;
    acc(1'b1, PAGE_CTRL, REG_SETUP, 8'h10);
    r8("clip", PAGE_CTRL, REG_FLAG, 8'h80);
    r8("clip_clr", PAGE_CTRL, REG_FLAG, 8'h00);
  endtask : sc_clip
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    sc_reset;
    sc_stopped;
    sc_stream;
    sc_adaptive;
    sc_clip;
    give_verdict;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    give_verdict;
  end
endmodule : dac_processing_coef_buffers_test
`default_nettype wire
